// ==== hw/sadc_regs.vh ====
`ifndef SADC_REGS_VH
`define SADC_REGS_VH

// Register byte offsets.
`define SADC_MODE_OFF 4'h0
`define SADC_CHAN_OFF 4'h4
`define SADC_RESULT_OFF 4'h8
`define SADC_FLAG_OFF 4'hC

// Mode and channel register fields.
`define SADC_MODE_EN_BIT 7
`define SADC_MODE_TRG_BIT 6
`define SADC_MODE_EDGE_HI 2
`define SADC_MODE_EDGE_LO 1
`define SADC_MODE_MASK 8'hC6
`define SADC_CHAN_MASK 8'h03

// Edge selections for the external trigger.
`define SADC_EDGE_RISE 2'h0
`define SADC_EDGE_FALL 2'h1
`define SADC_EDGE_BOTH 2'h2

// Conversion period in clock cycles, and the divisor that sets its sampling share.
`define SADC_CONV_CYCLES 144
`define SADC_SAMPLE_DIV 10

// AXI response codes.
`define SADC_RESP_OKAY 2'h0
`define SADC_RESP_SLVERR 2'h2

`endif

// ==== hw/sadc_sar.v ====
`include "sadc_regs.vh"

module sadc_sar #(
    parameter CONV_CYCLES = `SADC_CONV_CYCLES,
    parameter CNT_W = 8
) (
    // Clock and reset.
    input wire aclk,
    input wire aresetn,
    // Control.
    input wire start,
    input wire abort,
    // Analog front end.
    input wire comp_in,
    output reg sample_en,
    output reg [9:0] dac_code,
    // Result.
    output reg busy,
    output reg done,
    output reg [9:0] code
);

    // -------------------------------------------------------------
    // Sampling and successive approximation
    // -------------------------------------------------------------
    localparam [CNT_W-1:0] SAMPLE_CYC =
        CONV_CYCLES / `SADC_SAMPLE_DIV;
    localparam [CNT_W-1:0] LAST_CYC = CONV_CYCLES - 1;
    // One spare cycle lets the last bit decision land before the code
    // is latched; without it bit 0 is lost when the period divides evenly.
    localparam [CNT_W-1:0] BIT_CYC =
        (CONV_CYCLES - SAMPLE_CYC - 1) / 10;

    reg [CNT_W-1:0] cnt_r;
    reg [CNT_W-1:0] bit_cnt_r;
    reg [3:0] bit_idx_r;
    reg [9:0] sar_r;

    always @(posedge aclk) begin
        done <= 1'b0;
        if (!aresetn || abort) begin
            busy <= 1'b0;
            sample_en <= 1'b0;
            cnt_r <= {CNT_W{1'b0}};
            bit_cnt_r <= {CNT_W{1'b0}};
            bit_idx_r <= 4'h9;
            sar_r <= 10'h000;
            dac_code <= 10'h000;
            if (!aresetn) begin
                code <= 10'h000;
            end
        end else if (start) begin
            // The period begins with sampling and includes it.
            busy <= 1'b1;
            sample_en <= 1'b1;
            cnt_r <= {CNT_W{1'b0}};
            bit_cnt_r <= {CNT_W{1'b0}};
            bit_idx_r <= 4'h9;
            sar_r <= 10'h000;
            dac_code <= 10'h200;
        end else if (busy) begin
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r == SAMPLE_CYC - 1'b1) begin
                sample_en <= 1'b0;
            end
            if (!sample_en && bit_idx_r != 4'hF) begin
                if (bit_cnt_r == BIT_CYC - 1'b1) begin
                    // Keep the trial bit when input is at or above tap.
                    bit_cnt_r <= {CNT_W{1'b0}};
                    sar_r <= comp_in ? dac_code : sar_r;
                    if (bit_idx_r != 4'h0) begin
                        dac_code <= (comp_in ? dac_code : sar_r) |
                            (10'h001 << (bit_idx_r - 1'b1));
                    end
                    bit_idx_r <= bit_idx_r - 1'b1;
                end else begin
                    bit_cnt_r <= bit_cnt_r + 1'b1;
                end
            end
            if (cnt_r == LAST_CYC) begin
                busy <= 1'b0;
                done <= 1'b1;
                code <= sar_r;
            end
        end
    end

endmodule

// ==== hw/sadc_ctrl.v ====
// Overview of operation
// - A CPU result read in the store cycle completes first; store follows.
// - Trigger edges during a conversion, including the store cycle, are ignored.
// - Mode or channel write at completion wins; no store, no interrupt.
// - Channel writes never clear the conversion-end flag.
// - Old-channel result and flag may be set just before a channel change.
// - Standby halts all conversion activity.
// - Results are 10-bit codes, full scale divided into 1024 steps.
// - Sampling switch closes for about one tenth of each conversion.
// - Conversion period runs from sampling start until the code is ready.
// - Mode or channel writes may corrupt the result; read it first.
// - Completion coinciding with stop may leave the result undefined.
// - Each of four analog pins is shared with a digital port pin.
// - Enabled software mode converts repeatedly, storing and interrupting.
// - Enabled trigger mode converts once per valid external edge.
// - Writing enable 1 restarts conversion; writing 0 stops at once.
// - Channel rewrite aborts; software mode restarts, trigger mode waits.
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`include "sadc_regs.vh"

module sadc_ctrl #(
    parameter CONV_CYCLES = `SADC_CONV_CYCLES
) (
    // Clock and reset.
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address and data.
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response.
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read.
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Chip state and trigger.
    input wire standby,
    input wire external_trigger_input,
    // Shared pins and analog front end.
    input wire [3:0] shared_port_pin,
    input wire comp_in,
    output reg [3:0] port_in_r,
    output reg [3:0] analog_input_pin_sel_r,
    output reg sample_en_r,
    output reg [9:0] dac_code_r,
    // Interrupt request pulse.
    output reg conversion_end_irq
);

    // -------------------------------------------------------------
    // Register state
    // -------------------------------------------------------------
    reg [7:0] converter_mode_reg;
    reg [1:0] channel_select_reg;
    reg [9:0] conversion_result_reg;
    reg conversion_end_flag;
    reg [9:0] pend_code_r;
    reg pend_r;
    reg trg_s1_r;
    reg trg_s2_r;
    reg trg_d_r;
    reg [3:0] pin_s1_r;
    reg [3:0] pin_s2_r;
    reg [3:0] aw_addr_r;
    reg aw_have_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg w_have_r;

    wire en = converter_mode_reg[`SADC_MODE_EN_BIT];
    wire trg_mode = converter_mode_reg[`SADC_MODE_TRG_BIT];
    wire [1:0] edge_sel =
        converter_mode_reg[`SADC_MODE_EDGE_HI:`SADC_MODE_EDGE_LO];

    // -------------------------------------------------------------
    // Bus decode
    // -------------------------------------------------------------
    function is_mapped;
        input [3:0] a;
        begin
            is_mapped = (a == `SADC_MODE_OFF) || (a == `SADC_CHAN_OFF) ||
                (a == `SADC_RESULT_OFF) || (a == `SADC_FLAG_OFF);
        end
    endfunction

    // A write fires once both address and data are held.
    wire wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
    wire wr_lane0 = wr_go && w_strb_r[0];
    wire wr_mode = wr_lane0 && aw_addr_r == `SADC_MODE_OFF;
    wire wr_chan = wr_lane0 && aw_addr_r == `SADC_CHAN_OFF;
    wire wr_flag = wr_lane0 && aw_addr_r == `SADC_FLAG_OFF;
    wire rd_go = s_axi_arvalid && s_axi_arready;
    wire rd_result = rd_go && s_axi_araddr == `SADC_RESULT_OFF;

    // -------------------------------------------------------------
    // Conversion control
    // -------------------------------------------------------------
    wire busy;
    wire done;
    wire [9:0] code;
    wire sample_en;
    wire [9:0] dac_code;
    wire [7:0] mode_new = w_data_r[7:0] & `SADC_MODE_MASK;
    wire new_en = wr_mode ? mode_new[`SADC_MODE_EN_BIT] : en;
    wire new_trg = wr_mode ? mode_new[`SADC_MODE_TRG_BIT] : trg_mode;
    wire active = new_en && !standby;
    wire [1:0] new_edge = wr_mode ?
        mode_new[`SADC_MODE_EDGE_HI:`SADC_MODE_EDGE_LO] : edge_sel;

    wire trg_rise = trg_s2_r && !trg_d_r;
    wire trg_fall = !trg_s2_r && trg_d_r;
    wire trg_edge = (edge_sel == `SADC_EDGE_RISE) ? trg_rise :
        (edge_sel == `SADC_EDGE_FALL) ? trg_fall :
        (edge_sel == `SADC_EDGE_BOTH) ? (trg_rise | trg_fall) : 1'b0;

    // Edges count only when idle; busy is already low in the done cycle.
    wire trg_ok = trg_edge && !busy && !done && new_edge == edge_sel;
    wire reg_wr = wr_mode || wr_chan;
    wire abort = reg_wr || !active;
    wire sw_start = active && !new_trg &&
        (reg_wr || done || !busy);
    wire hw_start = active && new_trg && !reg_wr && trg_ok;
    wire start = sw_start || hw_start;
    // A mode or channel write in the done cycle drops the result.
    wire store_ok = done && !reg_wr;

    sadc_sar #(
        .CONV_CYCLES(CONV_CYCLES),
        .CNT_W(8)
    ) u_sar (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(start),
        .abort(abort && !start),
        .comp_in(comp_in),
        .sample_en(sample_en),
        .dac_code(dac_code),
        .busy(busy),
        .done(done),
        .code(code)
    );

    // -------------------------------------------------------------
    // Registers, result store and flag
    // -------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            converter_mode_reg <= 8'h00;
            channel_select_reg <= 2'h0;
            conversion_result_reg <= 10'h000;
            conversion_end_flag <= 1'b0;
            conversion_end_irq <= 1'b0;
            pend_code_r <= 10'h000;
            pend_r <= 1'b0;
        end else begin
            conversion_end_irq <= 1'b0;
            if (wr_mode) begin
                converter_mode_reg <= mode_new;
            end
            if (wr_chan) begin
                channel_select_reg <= w_data_r[1:0];
            end
            if (wr_flag && !w_data_r[0]) begin
                conversion_end_flag <= 1'b0;
            end
            if (store_ok && rd_result) begin
                // Read has priority; the store waits one cycle.
                pend_code_r <= code;
                pend_r <= 1'b1;
            end else if (store_ok || pend_r) begin
                conversion_result_reg <= pend_r ? pend_code_r : code;
                pend_r <= 1'b0;
                // Setting wins over a same-cycle clear.
                conversion_end_flag <= 1'b1;
                conversion_end_irq <= 1'b1;
            end
        end
    end

    // -------------------------------------------------------------
    // Pins: synchronisers and channel routing
    // -------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            trg_s1_r <= 1'b0;
            trg_s2_r <= 1'b0;
            trg_d_r <= 1'b0;
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
            port_in_r <= 4'h0;
            analog_input_pin_sel_r <= 4'h0;
            sample_en_r <= 1'b0;
            dac_code_r <= 10'h000;
        end else begin
            trg_s1_r <= external_trigger_input;
            trg_s2_r <= trg_s1_r;
            trg_d_r <= trg_s2_r;
            pin_s1_r <= shared_port_pin;
            pin_s2_r <= pin_s1_r;
            port_in_r <= pin_s2_r;
            analog_input_pin_sel_r <= busy ?
                (4'h1 << channel_select_reg) : 4'h0;
            sample_en_r <= sample_en;
            dac_code_r <= dac_code;
        end
    end

    // -------------------------------------------------------------
    // AXI4-Lite slave
    // -------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SADC_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SADC_RESP_OKAY;
            aw_addr_r <= 4'h0;
            aw_have_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
            w_have_r <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_r && !s_axi_awready;
            s_axi_wready <= !w_have_r && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r <= s_axi_awaddr;
                aw_have_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
                w_have_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= is_mapped(aw_addr_r) ?
                    `SADC_RESP_OKAY : `SADC_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
            end
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready &&
                s_axi_arvalid;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= is_mapped(s_axi_araddr) ?
                    `SADC_RESP_OKAY : `SADC_RESP_SLVERR;
                case (s_axi_araddr)
                    `SADC_MODE_OFF: begin
                        s_axi_rdata <= {24'h00_0000, converter_mode_reg};
                    end
                    `SADC_CHAN_OFF: begin
                        s_axi_rdata <= {30'h0000_0000, channel_select_reg};
                    end
                    `SADC_RESULT_OFF: begin
                        s_axi_rdata <= {22'h00_0000, conversion_result_reg};
                    end
                    `SADC_FLAG_OFF: begin
                        s_axi_rdata <= {31'h0000_0000, conversion_end_flag};
                    end
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                    end
                endcase
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// ==== verif/sadc_ctrl_checker.sv ====
`include "sadc_regs.vh"

module sadc_ctrl_checker #(
    parameter CONV_CYCLES = `SADC_CONV_CYCLES
) (
    // Clock and reset.
    input wire aclk,
    input wire aresetn,
    // Bus handshakes.
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    // Converter side.
    input wire standby,
    input wire [3:0] analog_input_pin_sel_r,
    input wire sample_en_r,
    input wire conversion_end_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    reg [7:0] samp_cnt_r;
    always @(posedge aclk) begin
        if (!aresetn)
            samp_cnt_r <= 8'h00;
        else
            samp_cnt_r <= sample_en_r ? samp_cnt_r + 8'h01 : 8'h00;
    end

    sequence s_sample_start;
        $rose(sample_en_r);
    endsequence
    sequence s_no_store;
        !conversion_end_irq [*8];
    endsequence

    chk_standby_halt: assert property (
        standby [*3] |-> analog_input_pin_sel_r == 4'h0 && !sample_en_r)
        else $error("converter active in standby");
    chk_standby_noirq: assert property (
        standby [*3] |-> !conversion_end_irq)
        else $error("interrupt raised in standby");
    chk_irq_pulse: assert property (
        conversion_end_irq |=> !conversion_end_irq)
        else $error("interrupt longer than one cycle");
    chk_sample_share: assert property (
        samp_cnt_r <= CONV_CYCLES / `SADC_SAMPLE_DIV)
        else $error("sampling window too long");
    chk_one_channel: assert property (
        $onehot0(analog_input_pin_sel_r))
        else $error("more than one pin routed");
    chk_period_start: assert property (
        s_sample_start |-> ##2 s_no_store)
        else $error("result stored too soon after sampling");
    chk_read_answer: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_write_resp: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
endmodule

bind sadc_ctrl sadc_ctrl_checker #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .standby(standby),
    .analog_input_pin_sel_r(analog_input_pin_sel_r),
    .sample_en_r(sample_en_r),
    .conversion_end_irq(conversion_end_irq)
);

// ==== verif/sadc_analog_model.sv ====
module sadc_analog_model (
    // Pin levels, ten bits a channel.
    input wire [39:0] levels,
    // Converter side.
    input wire [3:0] sel,
    input wire [9:0] dac_code,
    output logic comp_in,
    output logic [3:0] port_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // An unrouted comparator gives no stable answer, so it wobbles with the tap.
    always_comb begin
        comp_in = ^dac_code;
        for (int i = 0; i < 4; i++) begin
            if (sel[i])
                comp_in = levels[i*10 +: 10] >= dac_code;
            port_pin[i] = levels[i*10 + 9];
        end
    end
endmodule

// ==== verif/sadc_ctrl_test.sv ====
`include "sadc_regs.vh"

module sadc_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CONV = 40;
    localparam [39:0] LVL = {10'h3ff, 10'h155, 10'h2a5, 10'h001};
    logic aclk = 0, aresetn = 0, standby = 0, external_trigger_input = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic s_axi_bready = 1, s_axi_rready = 1;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, comp_in, sample_en_r, conversion_end_irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [3:0] shared_port_pin, port_in_r, analog_input_pin_sel_r;
    wire [9:0] dac_code_r;
    int mismatches = 0, compares = 0, irqs = 0, c;
    int exp_trg[4] = '{1, 2, 2, 0};

    sadc_ctrl #(.CONV_CYCLES(CONV)) DUT (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .standby(standby),
        .external_trigger_input(external_trigger_input),
        .shared_port_pin(shared_port_pin),
        .comp_in(comp_in),
        .port_in_r(port_in_r),
        .analog_input_pin_sel_r(analog_input_pin_sel_r),
        .sample_en_r(sample_en_r),
        .dac_code_r(dac_code_r),
        .conversion_end_irq(conversion_end_irq)
    );
    sadc_analog_model u_pins (.levels(LVL), .sel(analog_input_pin_sel_r),
        .dac_code(dac_code_r), .comp_in(comp_in),
        .port_pin(shared_port_pin));

    always #4 aclk = ~aclk;
    // Counted late in the step so tasks reading it at the edge never race.
    always @(posedge aclk) if (conversion_end_irq === 1'b1) irqs <= irqs + 1;

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Every handshake and interrupt wait goes through here, so a hang ends the run.
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 2000) begin
            chk(32'h0000_0000, 32'h0000_0001);
            wrap_up;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        int n;
        logic aw, w;
        n = 0;
        aw = 1;
        w = 1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        while (aw || w) begin
            tick(n);
            if (aw && s_axi_awready === 1'b1) begin
                aw = 0;
                s_axi_awvalid <= 0;
            end
            if (w && s_axi_wready === 1'b1) begin
                w = 0;
                s_axi_wvalid <= 0;
            end
        end
        while (s_axi_bvalid !== 1'b1) tick(n);
        chk({30'h0, s_axi_bresp}, {30'h0, `SADC_RESP_OKAY});
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do begin
            tick(n);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
        end while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata, exp);
        chk({30'h0, s_axi_rresp}, {30'h0, `SADC_RESP_OKAY});
    endtask
    task automatic wirq;
        int n, k;
        n = 0;
        k = irqs;
        while (irqs == k) tick(n);
    endtask
    task automatic idle(input int k);
        repeat (k) @(posedge aclk);
    endtask

    initial begin
        idle(12);
        aresetn <= 1;
        idle(2);
        for (int i = 0; i < 4; i++) rd(4'(i * 4), 32'h0000_0000);
        chk({28'h0, port_in_r}, 32'h0000_000a);
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            wr(`SADC_CHAN_OFF, i);
            if (i == 0) wr(`SADC_MODE_OFF, 32'h0000_0080);
            wirq;
            wirq;
            rd(`SADC_RESULT_OFF, {22'h0, LVL[i*10 +: 10]});
            rd(`SADC_FLAG_OFF, 32'h0000_0001);
        end
        wr(`SADC_CHAN_OFF, 32'h0000_0000);
        rd(`SADC_FLAG_OFF, 32'h0000_0001);
        wr(`SADC_FLAG_OFF, 32'h0000_0000);
        rd(`SADC_FLAG_OFF, 32'h0000_0000);
        wirq;
        wr(`SADC_RESULT_OFF, 32'h0000_0155);
        rd(`SADC_RESULT_OFF, {22'h0, LVL[9:0]});
        $display("test software mode done");
        standby <= 1;
        idle(3);
        c = irqs;
        idle(3 * CONV);
        chk(irqs - c, 0);
        chk({28'h0, analog_input_pin_sel_r}, 32'h0000_0000);
        standby <= 0;
        wirq;
        wr(`SADC_MODE_OFF, 32'h0000_0000);
        standby <= 1;
        idle(2);
        c = irqs;
        idle(3 * CONV);
        chk(irqs - c, 0);
        chk({31'h0, sample_en_r}, 32'h0000_0000);
        standby <= 0;
        $display("test standby and stop done");
        for (int e = 0; e < 4; e++) begin
            wr(`SADC_FLAG_OFF, 32'h0000_0000);
            wr(`SADC_MODE_OFF, 32'h0000_00c0 | (e << 1));
            rd(`SADC_MODE_OFF, 32'h0000_00c0 | (e << 1));
            c = irqs;
            external_trigger_input <= 1;
            idle(6);
            external_trigger_input <= 0;
            idle(6);
            external_trigger_input <= 1;
            idle(3 * CONV);
            external_trigger_input <= 0;
            idle(2 * CONV);
            chk(irqs - c, exp_trg[e]);
        end
        $display("test trigger mode done");
        wrap_up;
    end
endmodule
